// >>> src/intc_regs.svh
// Constants of the interrupt acceptance block
//
// Operation
// - Mask scheme select 1: maskable requests gated by interrupt mask bit alone.
// - Non-maskable request always accepted except in reset or hardware standby.
// - Each maskable source has an enable bit; disabled requests never reach selection.
// - Scheme 1: mask bit 1 blocks all maskable; level 1 outranks level 0.
// - Highest level wins; ties broken by fixed source order; others stay pending.
// - Exception handling starts only after current instruction completes.
// - Program counter and condition register pushed; pushed counter is return address.
// - Scheme 1: after stacking, set interrupt mask bit to 1.
// - Scheme 0: after stacking, set interrupt mask and user mask bits.
// - Form vector address, read handler address, start service routine there.
// - Scheme 0: level 0 requests blocked whenever interrupt mask bit is 1.
// - Scheme 0: level 1 blocked only when both mask bits are 1.
// - Scheme 0 with mask bit 0: accept any selected request.
// - Priority decision takes 2 states external, 1 state on-chip.
// - Stack, vector, prefetch: 4, 8 or 12 states by bus type.
// - Internal processing takes 4 states whatever the memory.
// - Instruction completion wait: 1-23, up to 27, up to 31 states.
// - Wait states on three-state external access lengthen each memory phase.
// - Prefetch phase: one prefetch after acceptance plus first handler instruction.
// - Smaller vector number has higher default priority, applies after reset.
// - Eight external request lines use vectors 12 to 19, any pin direction.
// - Vector slot is four bytes; low 16 address bits are four times number.
`ifndef INTC_REGS_SVH
`define INTC_REGS_SVH
`define NMI_VECTOR      6'h07
`define EXT_VECTOR_BASE 6'h0c
`define INT_VECTOR_BASE 6'h14
`define EXT_DECIDE_ST   3'h2
`define INT_DECIDE_ST   3'h1
`define MEM_ST_ONCHIP   5'h04
`define MEM_ST_8B2      5'h08
`define MEM_ST_8B3      5'h0c
`define INTERNAL_ST     5'h04
`define WAIT_MAX_ONCHIP 6'h17
`define WAIT_MAX_8B2    6'h1b
`define WAIT_MAX_8B3    6'h1f
`endif

// >>> src/intc_pkg.sv
// Types of the interrupt acceptance block
package intc_pkg;
  typedef enum logic [1:0] {BUS_ONCHIP, BUS_16B2, BUS_8B2, BUS_8B3} bus_kind_t;
  typedef struct packed {
    logic       valid;
    logic       external;
    logic       level;
    logic [5:0] vector;
  } pick_t;
  typedef struct packed {
    logic       maskBit;
    logic       userMaskBit;
  } ccr_mask_t;
  typedef enum logic [2:0] {
    PH_STACK, PH_VECTOR, PH_PREFETCH, PH_INTERNAL, PH_FETCH_FIRST
  } phase_t;
endpackage : intc_pkg

// >>> src/intc_phase_timer.sv
// Down counter that times one phase of the response sequence
`timescale 1ns/100ps
module intc_phase_timer
  import intc_pkg::*;
#(
  parameter int W = 6
) (
  // Clock and control
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         ce,
  // Load and status
  input  wire logic         load,
  input  wire logic [W-1:0] loadValue,
  input  wire logic         extend,
  output logic              done
);
  logic [W-1:0] count;
  wire          running = count != '0;
  wire          lastTick = (count == W'(1)) && !extend;

  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
    end else if (ce) begin
      if (load) begin
        count <= loadValue;
      end else if (running && !extend) begin
        count <= count - W'(1);
      end
    end
  end

  assign done = running && lastTick && ce;
endmodule : intc_phase_timer

// >>> src/intc_select.sv
// Masking and priority selection of enabled requests
`timescale 1ns/100ps
`include "intc_regs.svh"
module intc_select
  import intc_pkg::*;
#(
  parameter int NEXT = 8,
  parameter int NINT = 16
) (
  // Requests and enables
  input  wire logic [NEXT-1:0] extReq,
  input  wire logic [NEXT-1:0] extEnable,
  input  wire logic [NEXT-1:0] extLevel,
  input  wire logic [NINT-1:0] intReq,
  input  wire logic [NINT-1:0] intEnable,
  input  wire logic [NINT-1:0] intLevel,
  // Mask state
  input  wire logic            maskSchemeSelect,
  input  wire ccr_mask_t       ccrMask,
  // Result
  output pick_t                pick
);
  localparam int N = NEXT + NINT;
  wire [N-1:0] req = {intReq & intEnable, extReq & extEnable};
  wire [N-1:0] lvl = {intLevel, extLevel};
  // Scheme 1 ignores the user mask bit; scheme 0 lets level 1 pass with user mask 0
  wire passLevel0 = !ccrMask.maskBit;
  wire passLevel1 = !ccrMask.maskBit ||
                    (!maskSchemeSelect && !ccrMask.userMaskBit);
  wire [N-1:0] open = req & ((lvl & {N{passLevel1}}) | (~lvl & {N{passLevel0}}));
  wire [N-1:0] hiSet = open & lvl;
  wire [N-1:0] useSet = (hiSet != '0) ? hiSet : open;

  always_comb begin
    pick = '0;
    // Lowest index is the smallest vector number and wins ties
    for (int i = N - 1; i >= 0; i--) begin
      if (useSet[i]) begin
        pick.valid    = 1'b1;
        pick.external = i < NEXT;
        pick.level    = lvl[i];
        pick.vector   = (i < NEXT) ? `EXT_VECTOR_BASE + 6'(i)
                                   : `INT_VECTOR_BASE + 6'(i - NEXT);
      end
    end
  end
endmodule : intc_select

// >>> src/intc_accept.sv
// Interrupt acceptance and exception-handling sequencer
`timescale 1ns/100ps
`include "intc_regs.svh"
module intc_accept
  import intc_pkg::*;
#(
  parameter int NEXT = 8,
  parameter int NINT = 16
) (
  // Clock, reset, enable
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire logic            ce,
  input  wire logic            hardwareStandby,
  // Request sources
  input  wire logic            nmiReq,
  input  wire logic [NEXT-1:0] extReq,
  input  wire logic [NEXT-1:0] extEnable,
  input  wire logic [NINT-1:0] intReq,
  input  wire logic [NINT-1:0] intEnable,
  // Configuration
  input  wire logic [NEXT-1:0] extLevel,
  input  wire logic [NINT-1:0] intLevel,
  input  wire logic            maskSchemeSelect,
  input  wire bus_kind_t       busKind,
  input  wire logic            waitRequest,
  // Condition register masks and counter from the core
  input  wire ccr_mask_t       ccrMask,
  input  wire logic [23:0]     returnCounter,
  // Sequencer handshake
  input  wire logic            instrDone,
  output logic                 cpuReq,
  output logic [5:0]           cpuVector,
  input  wire logic            cpuAck,
  // Exception handling effects
  output logic                 stackPush,
  output logic [23:0]          stackedCounter,
  output logic [7:0]           stackedCcrMask,
  output logic                 setMaskBit,
  output logic                 setUserMaskBit,
  output logic [15:0]          vectorAddress,
  output logic                 vectorFetch,
  output logic                 prefetch,
  output logic                 routineStart,
  output logic                 busy
);
  typedef enum {S_IDLE, S_DECIDE, S_OFFER, S_WAIT_INSTR, S_RUN} state_t;
  state_t state;
  phase_t phase;
  pick_t  pick;
  pick_t  held;
  logic [2:0] decideCount;
  logic [5:0] instrCount;
  logic       timerLoad;
  logic [5:0] timerValue;
  logic       timerDone;

  ////////////////////////////////////////////////////////////////////////////
  // Selection among maskable sources
  intc_select #(.NEXT(NEXT), .NINT(NINT)) u_select (
    .extReq           (extReq),
    .extEnable        (extEnable),
    .extLevel         (extLevel),
    .intReq           (intReq),
    .intEnable        (intEnable),
    .intLevel         (intLevel),
    .maskSchemeSelect (maskSchemeSelect),
    .ccrMask          (ccrMask),
    .pick             (pick)
  );

  // Non-maskable wins over anything, standby blocks it
  wire   nmiLive = nmiReq && !hardwareStandby;
  pick_t candidate;
  assign candidate = nmiLive ? pick_t'{valid: 1'b1, external: 1'b1, level: 1'b1,
                                       vector: `NMI_VECTOR} : pick;

  ////////////////////////////////////////////////////////////////////////////
  // Timing selected by memory type
  wire [4:0] memStates = (busKind == BUS_8B3) ? `MEM_ST_8B3 :
                         (busKind == BUS_8B2) ? `MEM_ST_8B2 : `MEM_ST_ONCHIP;
  wire [5:0] instrMax  = (busKind == BUS_8B3) ? `WAIT_MAX_8B3 :
                         (busKind == BUS_8B2) ? `WAIT_MAX_8B2 : `WAIT_MAX_ONCHIP;
  // Wait states only stretch three-state external accesses
  wire       memExtend = waitRequest && (busKind == BUS_8B3) &&
                         (phase != PH_INTERNAL);
  wire [2:0] decideStates = candidate.external ? `EXT_DECIDE_ST : `INT_DECIDE_ST;
  wire       instrEnd  = instrDone || (instrCount == instrMax);
  wire       lastPhase = phase == PH_FETCH_FIRST;

  always_comb begin
    timerLoad  = 1'b0;
    timerValue = 6'(memStates);
    if (state == S_WAIT_INSTR && instrEnd) begin
      timerLoad = 1'b1;
    end else if (state == S_RUN && timerDone && !lastPhase) begin
      timerLoad  = 1'b1;
      timerValue = (phase == PH_PREFETCH) ? 6'(`INTERNAL_ST) : 6'(memStates);
    end
  end

  intc_phase_timer #(.W(6)) u_timer (
    .mclk      (mclk),
    .reset     (reset),
    .ce        (ce),
    .load      (timerLoad),
    .loadValue (timerValue),
    .extend    (memExtend),
    .done      (timerDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance state machine
  always_ff @(posedge mclk) begin
    if (reset) begin
      state       <= S_IDLE;
      phase       <= PH_STACK;
      held        <= '0;
      decideCount <= 3'h0;
      instrCount  <= 6'h00;
    end else if (ce) begin
      unique case (state)
        S_IDLE: begin
          // Masked requests are not latched, so they stay pending at source
          if (candidate.valid) begin
            state       <= S_DECIDE;
            decideCount <= 3'h1;
          end
        end
        S_DECIDE: begin
          if (!candidate.valid) begin
            state <= S_IDLE;
          end else if (decideCount >= decideStates) begin
            held  <= candidate;
            state <= S_OFFER;
          end else begin
            decideCount <= decideCount + 3'h1;
          end
        end
        S_OFFER: begin
          if (cpuAck) begin
            state      <= S_WAIT_INSTR;
            instrCount <= 6'h01;
          end
        end
        S_WAIT_INSTR: begin
          if (instrEnd) begin
            state <= S_RUN;
            phase <= PH_STACK;
          end else begin
            instrCount <= instrCount + 6'h01;
          end
        end
        S_RUN: begin
          if (timerDone) begin
            unique case (phase)
              PH_STACK:       phase <= PH_VECTOR;
              PH_VECTOR:      phase <= PH_PREFETCH;
              PH_PREFETCH:    phase <= PH_INTERNAL;
              PH_INTERNAL:    phase <= PH_FETCH_FIRST;
              PH_FETCH_FIRST: state <= S_IDLE;
              default:        state <= S_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: effects and cpuVector held in flip-flops, cpuReq and phase strobes decoded from state
  wire stackEnd  = state == S_RUN && phase == PH_STACK && timerDone;
  wire startPush = state == S_WAIT_INSTR && instrEnd && ce;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cpuVector      <= 6'h00;
      stackedCounter <= 24'h000000;
      stackedCcrMask <= 8'h00;
      setMaskBit     <= 1'b0;
      setUserMaskBit <= 1'b0;
      vectorAddress  <= 16'h0000;
      routineStart   <= 1'b0;
    end else if (ce) begin
      cpuVector <= held.vector;
      if (startPush) begin
        stackedCounter <= returnCounter;
        stackedCcrMask <= {6'h00, ccrMask.userMaskBit, ccrMask.maskBit};
        vectorAddress  <= {8'h00, held.vector, 2'b00};
      end
      setMaskBit     <= stackEnd;
      setUserMaskBit <= stackEnd && !maskSchemeSelect;
      routineStart   <= state == S_RUN && lastPhase && timerDone;
    end
  end

  assign cpuReq      = state == S_OFFER;
  assign stackPush   = state == S_RUN && phase == PH_STACK;
  assign vectorFetch = state == S_RUN && phase == PH_VECTOR;
  assign prefetch    = state == S_RUN &&
                       (phase == PH_PREFETCH || phase == PH_FETCH_FIRST);
  assign busy        = state != S_IDLE;
endmodule : intc_accept

// >>> test/intc_accept_chk.sv
// Assertion checker for the interrupt acceptance sequencer
`timescale 1ns/100ps
module intc_accept_chk
  import intc_pkg::*;
#(
  parameter int NEXT = 8,
  parameter int NINT = 16
) (
  // Clock and reset
  input wire logic            mclk,
  input wire logic            reset,
  // Requests and masks
  input wire logic            nmiReq,
  input wire logic            hardwareStandby,
  input wire logic [NEXT-1:0] extReq,
  input wire logic [NEXT-1:0] extEnable,
  input wire logic [NINT-1:0] intReq,
  input wire logic [NINT-1:0] intEnable,
  input wire logic            maskSchemeSelect,
  input wire ccr_mask_t       ccrMask,
  input wire bus_kind_t       busKind,
  input wire logic            waitRequest,
  // Sequencer side
  input wire logic            instrDone,
  input wire logic            cpuReq,
  input wire logic [5:0]      cpuVector,
  input wire logic            cpuAck,
  input wire logic            stackPush,
  input wire logic            setMaskBit,
  input wire logic            setUserMaskBit,
  input wire logic [15:0]     vectorAddress,
  input wire logic            vectorFetch,
  input wire logic            prefetch,
  input wire logic            busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Taken at the handshake, where the lagging vector register has settled
  logic [5:0] ackVec;
  always_ff @(posedge mclk) begin
    if (cpuReq && cpuAck) begin
      ackVec <= cpuVector;
    end
  end
  ////////////////////////////////////////
  a_offer_holds: assert property (cpuReq && !cpuAck |=> cpuReq)
    else $error("offer dropped before acknowledge");
  a_nmi_decide: assert property (nmiReq && !hardwareStandby && !busy |-> ##3 cpuReq)
    else $error("non-maskable request not offered in time");
  a_onchip_decide: assert property (!busy && !nmiReq && extReq == '0 &&
    |(intReq & intEnable) && !ccrMask.maskBit |-> ##2 cpuReq) else $error("on-chip decide time");
  a_disabled_ignored: assert property (!busy && !nmiReq && !(|(extReq & extEnable)) &&
    !(|(intReq & intEnable)) |=> !busy) else $error("disabled source started a sequence");
  a_wait_instr: assert property ($rose(stackPush) |-> $past(instrDone))
    else $error("stacking before instruction end");
  a_stack_short: assert property ($rose(stackPush) && busKind inside {BUS_ONCHIP, BUS_16B2}
    |-> stackPush[*4] ##1 !stackPush) else $error("stack phase not 4 states");
  a_stack_narrow: assert property ($rose(stackPush) && busKind == BUS_8B2
    |-> stackPush[*8] ##1 !stackPush) else $error("stack phase not 8 states");
  a_mask_after: assert property ($fell(stackPush) |-> ##[0:2] setMaskBit)
    else $error("mask bit not set after stacking");
  a_user_scheme1: assert property (setUserMaskBit |-> !maskSchemeSelect)
    else $error("user mask set in scheme 1");
  a_user_scheme0: assert property (setMaskBit && !maskSchemeSelect |-> setUserMaskBit)
    else $error("user mask not set in scheme 0");
  a_vector_slot: assert property (vectorFetch |-> vectorAddress == {8'h00, ackVec, 2'h0})
    else $error("vector address not four times vector");
  a_wait_stretch: assert property (busKind == BUS_8B3 && waitRequest &&
    stackPush |=> stackPush) else $error("wait state did not stretch stacking");
  a_internal_four: assert property ($fell(prefetch) && busy |->
    !prefetch[*4] ##1 prefetch) else $error("internal processing not 4 states");
endmodule : intc_accept_chk

bind intc_accept intc_accept_chk #(.NEXT(NEXT), .NINT(NINT)) chk_u (
  .mclk, .reset, .nmiReq, .hardwareStandby, .extReq, .extEnable, .intReq, .intEnable,
  .maskSchemeSelect, .ccrMask, .busKind, .waitRequest, .instrDone, .cpuReq, .cpuVector,
  .cpuAck, .stackPush, .setMaskBit, .setUserMaskBit, .vectorAddress, .vectorFetch,
  .prefetch, .busy
);

// >>> test/cpu_seq_model.sv
// Behavioural model of the core's instruction sequencer
`timescale 1ns/100ps
module cpu_seq_model (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // Handshake
  input wire logic       cpuReq,
  input wire logic [4:0] lat,
  output logic           cpuAck,
  output logic           instrDone
);
  logic [4:0] cnt;
  logic       acked;
  always_ff @(posedge mclk) begin
    cpuAck    <= 1'h0;
    instrDone <= 1'h0;
    cnt       <= cnt + 5'h01;
    if (reset || !(cpuReq || acked)) begin
      cnt   <= 5'h00;
      acked <= 1'h0;
    end else if (cnt >= lat) begin
      // A long lat stands for a slow instruction still running
      cnt       <= 5'h00;
      acked     <= !acked;
      cpuAck    <= !acked;
      instrDone <= acked;
    end
  end
endmodule : cpu_seq_model

// >>> test/interrupt_accept_and_response_tb.sv
// Self-checking bench for the interrupt acceptance block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module interrupt_accept_and_response_tb
  import intc_pkg::*;
;
  typedef struct packed {
    logic [7:0] e, el;
    logic [15:0] i, il;
    logic en, sch, mi, mu;
    bus_kind_t bk;
    logic [5:0] v;
  } row_t;
  logic mclk, instrDone, cpuReq, cpuAck, stackPush, setMaskBit, setUserMaskBit;
  logic vectorFetch, prefetch, routineStart, busy;
  logic reset = 1'h1, ce = 1'h1, hardwareStandby = 1'h0, nmiReq = 1'h0;
  logic maskSchemeSelect = 1'h0, waitRequest = 1'h0;
  logic [7:0] extReq = 8'h00, extEnable = 8'h00, extLevel = 8'h00, stackedCcrMask;
  logic [15:0] intReq = 16'h0000, intEnable = 16'h0000, intLevel = 16'h0000, vectorAddress;
  bus_kind_t busKind = BUS_ONCHIP;
  ccr_mask_t ccrMask = '{1'h0, 1'h0};
  logic [23:0] returnCounter = 24'h0a5c30, stackedCounter;
  logic [5:0] cpuVector;
  logic [4:0] seqLat = 5'h01;
  int fails = 0, cmpCount = 0, cycles = 0;
  row_t rows [10] = '{
    '{8'h04, 8'h00, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h0, 1'h1, BUS_ONCHIP, 6'h0e},
    '{8'h81, 8'h00, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h0, 1'h0, BUS_16B2, 6'h0c},
    '{8'h01, 8'h00, 16'h0001, 16'h0001, 1'h1, 1'h1, 1'h0, 1'h0, BUS_8B2, 6'h14},
    '{8'h01, 8'h00, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h1, 1'h0, BUS_ONCHIP, 6'h00},
    '{8'h01, 8'h00, 16'h0002, 16'h0002, 1'h1, 1'h0, 1'h1, 1'h0, BUS_8B3, 6'h15},
    '{8'h01, 8'h00, 16'h0000, 16'h0000, 1'h1, 1'h0, 1'h1, 1'h0, BUS_ONCHIP, 6'h00},
    '{8'h00, 8'h00, 16'h0002, 16'h0002, 1'h1, 1'h0, 1'h1, 1'h1, BUS_ONCHIP, 6'h00},
    '{8'h80, 8'h00, 16'h0000, 16'h0000, 1'h1, 1'h0, 1'h0, 1'h1, BUS_16B2, 6'h13},
    '{8'h00, 8'h00, 16'h000c, 16'h0000, 1'h1, 1'h1, 1'h0, 1'h0, BUS_ONCHIP, 6'h16},
    '{8'h01, 8'h00, 16'h0000, 16'h0000, 1'h0, 1'h1, 1'h0, 1'h0, BUS_ONCHIP, 6'h00}};
  intc_accept dut_u (.mclk, .reset, .ce, .hardwareStandby, .nmiReq, .extReq, .extEnable,
    .intReq, .intEnable, .extLevel, .intLevel, .maskSchemeSelect, .busKind, .waitRequest,
    .ccrMask, .returnCounter, .instrDone, .cpuReq, .cpuVector, .cpuAck, .stackPush,
    .stackedCounter, .stackedCcrMask, .setMaskBit, .setUserMaskBit, .vectorAddress,
    .vectorFetch, .prefetch, .routineStart, .busy);
  cpu_seq_model seq_u (.mclk, .reset, .cpuReq, .lat(seqLat), .cpuAck, .instrDone);
  ////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // Three-state access: a wait after every stacking state, so stacking takes 2 * 12 - 1
  always @(posedge mclk) begin
    waitRequest <= busKind == BUS_8B3 && stackPush === 1'h1 && !waitRequest;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      testDone();
    end
  end
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : testDone
  task automatic waitReq(output bit got);
    got = 1'b0;
    repeat (12) begin
      @(negedge mclk);
      if (cpuReq === 1'h1) begin
        got = 1'b1;
        break;
      end
    end
  endtask : waitReq
  // Requests drop after the handshake, so a held source cannot start a second run
  task automatic serve(input logic [5:0] v);
    bit got;
    int pf, rs, sc, ms;
    waitReq(got);
    `CHK("taken", v != 6'h00, got)
    if (got) begin
      @(negedge mclk);
      `CHK("vector", v, cpuVector)
      repeat (40) begin
        if (cpuAck === 1'h1) break;
        @(negedge mclk);
      end
    end
    @(posedge mclk);
    extReq <= 8'h00;
    intReq <= 16'h0000;
    nmiReq <= 1'h0;
    repeat (300) begin
      @(negedge mclk);
      pf += int'(prefetch === 1'h1);
      rs += int'(routineStart === 1'h1);
      sc += int'(stackPush === 1'h1);
      if (busy === 1'h0) break;
    end
    ms = (busKind == BUS_8B3) ? 12 : (busKind == BUS_8B2) ? 8 : 4;
    `CHK("prefetch", got ? 2 * ms : 0, pf)
    `CHK("start", int'(got), rs)
    `CHK("stackLen", got ? ((busKind == BUS_8B3) ? 2 * ms - 1 : ms) : 0, sc)
    if (got) begin
      `CHK("stackedPc", returnCounter, stackedCounter)
      `CHK("vecAddr", {8'h00, v, 2'h0}, vectorAddress)
    end
  endtask : serve
  initial begin
    bit got;
    repeat (8) @(posedge mclk);
    `CHK("rstBusy", 1'h0, busy)
    reset <= 1'h0;
    for (int k = 0; k < 10; k++) begin
      @(posedge mclk);
      seqLat           <= k[0] ? 5'h10 : 5'h01;
      extReq           <= rows[k].e;
      intReq           <= rows[k].i;
      extLevel         <= rows[k].el;
      intLevel         <= rows[k].il;
      extEnable        <= {8{rows[k].en}};
      intEnable        <= {16{rows[k].en}};
      maskSchemeSelect <= rows[k].sch;
      ccrMask          <= '{rows[k].mi, rows[k].mu};
      busKind          <= rows[k].bk;
      serve(rows[k].v);
      if (rows[k].v != 6'h00) `CHK("ccr", {6'h00, rows[k].mu, rows[k].mi}, stackedCcrMask)
    end
    @(posedge mclk);
    ccrMask         <= '{1'h1, 1'h1};
    nmiReq          <= 1'h1;
    hardwareStandby <= 1'h1;
    waitReq(got);
    `CHK("standby", 1'h0, got)
    @(posedge mclk);
    hardwareStandby <= 1'h0;
    serve(6'h07);
    @(posedge mclk);
    extEnable <= 8'hff;
    extReq    <= 8'h02;
    waitReq(got);
    `CHK("held", 1'h0, got)
    @(posedge mclk);
    ccrMask <= '{1'h0, 1'h0};
    serve(6'h0d);
    @(posedge mclk);
    extReq <= 8'h01;
    waitReq(got);
    `CHK("midOffer", 1'h1, got)
    @(posedge mclk);
    reset <= 1'h1;
    repeat (2) @(negedge mclk);
    `CHK("midBusy", 1'h0, busy)
    `CHK("midReq", 1'h0, cpuReq)
    // Release with the clock enable low: the request must wait, not be lost
    @(posedge mclk);
    reset  <= 1'h0;
    ce     <= 1'h0;
    extReq <= 8'h81;
    waitReq(got);
    `CHK("frozen", 1'h0, got)
    @(posedge mclk);
    ce <= 1'h1;
    serve(6'h0c);
    repeat (4) @(posedge mclk);
    testDone();
  end
endmodule : interrupt_accept_and_response_tb
